//--- logic/sas_pkg.sv
// Shared constants, register layouts and state types of the converter sequencer.
package sas_pkg;

	// Structure of the block.
	localparam int NCONV        = 2;
	localparam int NCH          = 4;
	localparam int RES_W        = 8;

	// Conversion timing: least conversion time at the fastest converter clock.
	localparam int ADC_MAX_HZ   = 3_300_000;
	localparam int CONV_MIN_NS  = 3900;
	localparam int CONV_TICKS   = (CONV_MIN_NS * (ADC_MAX_HZ / 1000) + 999_999) / 1_000_000;
	localparam int SAMPLE_TICKS = CONV_TICKS - RES_W;
	localparam int PRE_DIV      = 4;

	localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_TICKS - 1);
	localparam logic [1:0] PRE_LAST    = 2'(PRE_DIV - 1);
	localparam logic [2:0] MSB_BIT     = 3'h7;
	localparam logic [2:0] LIM_BIT     = 3'h4;
	localparam logic [2:0] LSB_BIT     = 3'h0;
	localparam logic [7:0] SAR_INIT    = 8'h80;
	localparam logic [7:0] BIT_ONE     = 8'h01;
	localparam logic [1:0] POS_LAST    = 2'h3;
	localparam logic [1:0] RES_DAC     = 2'h3;

	// Register indices within one converter's bank.
	localparam logic [3:0] REG_CTRL    = 4'h0;
	localparam logic [3:0] REG_CHAN    = 4'h1;
	localparam logic [3:0] REG_LIMHI   = 4'h2;
	localparam logic [3:0] REG_LIMLO   = 4'h3;
	localparam logic [3:0] REG_STAT    = 4'h4;
	localparam logic [3:0] REG_IEN     = 4'h5;
	localparam logic [3:0] REG_CLKDIV  = 4'h6;
	localparam logic [3:0] REG_CMD     = 4'h7;
	localparam logic [1:0] REG_RES_WIN = 2'h2;

	typedef enum logic [2:0] {
		MD_FIX_SINGLE,
		MD_FIX_CONT,
		MD_SCAN_SINGLE,
		MD_SCAN_CONT,
		MD_DUAL_CONT,
		MD_SINGLE_STEP
	} sas_mode_t;

	typedef enum logic [1:0] {ST_TIMER, ST_IMMEDIATE, ST_EDGE, ST_DUAL} sas_start_t;

	typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_SAMPLE, PH_CONV} sas_phase_t;

	typedef struct packed {
		logic       rsv;
		logic       dac;
		logic       en;
		sas_start_t start;
		sas_mode_t  mode;
	} sas_ctrl_t;

	typedef struct packed {
		logic [1:0] second;
		logic [1:0] first;
		logic [3:0] mask;
	} sas_chan_t;

	typedef struct packed {
		logic [5:0] rsv;
		logic       lim;
		logic       done;
	} sas_ien_t;

	typedef struct packed {
		logic [4:0] rsv;
		logic       busy;
		logic       lim;
		logic       done;
	} sas_stat_t;

	typedef struct packed {
		logic [5:0] rsv;
		logic       stop;
		logic       start;
	} sas_cmd_t;

	typedef struct packed {
		logic       bank;
		logic       conv;
		logic [3:0] idx;
	} sas_addr_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		sas_addr_t  addr;
		logic [7:0] wdata;
	} sas_bus_t;

	typedef struct packed {
		logic [1:0] ch_sel;
		logic       sample;
		logic [7:0] dac_code;
		logic       dac_pin_en;
	} sas_ana_t;

	typedef struct packed {
		sas_ctrl_t       ctrl;
		sas_chan_t       chan;
		logic [7:0]      lim_hi;
		logic [7:0]      lim_lo;
		logic [2:0]      div;
		logic            done_ie;
		logic            lim_ie;
		logic            done_f;
		logic            lim_f;
		sas_phase_t      ph;
		logic            go;
		logic [3:0]      tcnt;
		logic [2:0]      dcnt;
		logic [7:0]      sar;
		logic [2:0]      bitn;
		logic            full_chk;
		logic [1:0]      ch;
		logic [1:0]      pos;
		logic [3:0][7:0] res;
		sas_ana_t        ana;
	} sas_conv_t;

	typedef struct packed {
		sas_conv_t [NCONV-1:0] cv;
		logic [1:0]            pre;
		logic                  edge_s1;
		logic                  edge_s2;
		logic                  edge_p;
		logic [NCONV-1:0]      comp_s1;
		logic [NCONV-1:0]      comp_s2;
		logic [7:0]            rdata;
		logic                  irq;
	} sas_state_t;

	// Lowest enabled channel at or above from; the top bit says one was found.
	function automatic logic [2:0] sas_scan_next(input logic [3:0] mask, input logic [2:0] from);
		logic [2:0] r;
		r = 3'h0;
		for (int k = NCH - 1; k >= 0; k--)
		begin
			if (mask[k] && (3'(k) >= from))
				r = {1'b1, 2'(k)};
		end
		return r;
	endfunction : sas_scan_next

	function automatic logic sas_is_scan(input sas_mode_t m);
		return (m == MD_SCAN_SINGLE) || (m == MD_SCAN_CONT) || (m == MD_SINGLE_STEP);
	endfunction : sas_is_scan

endpackage : sas_pkg

//--- logic/sas_sequencer.sv
// Sequencer and SAR control for two 4-channel 8-bit converters with common control.
//
// Functional notes
// - Each converter has four 8-bit result registers and a 4-input channel multiplexer.
// - Fixed single mode converts the chosen input once into its own result register.
// - Fixed continuous mode fills results 0 to 3 in turn, flagging every fourth.
// - Fixed and dual continuous modes wrap to result 0; continuous modes overwrite and run until software stops them.
// - Auto-scan single converts each enabled input once, flagging after the last.
// - Auto-scan continuous restarts from the lowest enabled input after flagging.
// - Dual continuous alternates two inputs into results 0 to 3, then flags.
// - Single-step converts one enabled input per start, flags, then waits.
// - Timer overflow starts a conversion; overflows during a conversion are ignored.
// - Immediate start begins at once and works with every operating mode; in single-step each such start restarts at the lowest enabled input.
// - Either edge on the trigger pin starts; edges during conversion are ignored.
// - Dual start launches both converters together from a trigger on either.
// - Upper four result bits are checked against the limit nibbles once resolved.
// - An in-range partial result is checked again in full after completion.
// - No limit event is raised while the limit interrupt enable is clear.
// - In DAC mode result register 3 drives the DAC onto the channel 3 pin.
// - A divider from 1 to 8 forms the converter clock.
// - A conversion takes at least the least time at the fastest converter clock.
// - The converter runs during processor idle and its interrupt wakes the processor.
// - In power-down the converter logic stops.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sas_sequencer
(
	// Clock and reset.
	input  wire logic                            clock,
	input  wire logic                            rst,
	// Register port.
	input  wire sas_pkg::sas_bus_t               bus,
	output      logic [7:0]                      rd_data,
	// Start sources and power state.
	input  wire logic                            timer_ovf,
	input  wire logic                            edge_trigger_pin,
	input  wire logic                            power_down,
	// Analogue front end.
	input  wire logic [sas_pkg::NCONV-1:0]       comparator,
	output      sas_pkg::sas_ana_t [sas_pkg::NCONV-1:0] ana_out,
	// Interrupt request.
	output      logic                            irq
);

	localparam sas_pkg::sas_state_t STATE_RST = '0;

	sas_pkg::sas_state_t q;
	sas_pkg::sas_state_t d;

	logic                       pre_tick;
	logic                       edge_ev;
	logic                       dual_any;
	logic [sas_pkg::NCONV-1:0]  tick;
	logic [sas_pkg::NCONV-1:0]  own;
	logic [sas_pkg::NCONV-1:0]  strt;
	logic [sas_pkg::NCONV-1:0]  ctl_wr;

	assign pre_tick = (q.pre == sas_pkg::PRE_LAST);
	assign edge_ev  = q.edge_s2 ^ q.edge_p;
	assign dual_any = (q.cv[0].ctrl.en && (q.cv[0].ctrl.start == sas_pkg::ST_DUAL))
		|| (q.cv[1].ctrl.en && (q.cv[1].ctrl.start == sas_pkg::ST_DUAL));

	for (genvar g = 0; g < sas_pkg::NCONV; g++)
	begin : g_conv
		// Control writes restart or stop the converter and take priority over the engine.
		assign ctl_wr[g] = bus.wr && !bus.addr.bank && (bus.addr.conv == 1'(g))
			&& ((bus.addr.idx == sas_pkg::REG_CTRL) || (bus.addr.idx == sas_pkg::REG_CMD));
		// Converter clock enable; frozen in power-down.
		assign tick[g] = pre_tick && (q.cv[g].dcnt == q.cv[g].div) && !power_down;
		assign own[g] = (q.cv[g].ctrl.start == sas_pkg::ST_TIMER) ? timer_ovf
			: (q.cv[g].ctrl.start == sas_pkg::ST_EDGE) ? edge_ev
			: q.cv[g].go;
		// Starts are only heard while armed, so triggers during a conversion are ignored.
		assign strt[g] = (q.cv[g].ph == sas_pkg::PH_ARMED) && !power_down && !ctl_wr[g]
			&& (own[g] || (dual_any && own[1 - g]));
	end

	always_comb
	begin
		sas_pkg::sas_ctrl_t ctl;
		sas_pkg::sas_cmd_t  cmd;
		logic [7:0]         nv;
		logic [2:0]         nx;
		logic [1:0]         idx;
		logic               arm;
		logic               halt;
		logic               irq_v;
		logic [7:0]         rd_v;
		sas_pkg::sas_ien_t  ien;
		ctl   = '0;
		ien   = '0;
		cmd   = '0;
		nv    = '0;
		nx    = '0;
		idx   = '0;
		arm   = 1'b0;
		halt  = 1'b0;
		irq_v = 1'b0;
		rd_v  = '0;
		d = q;
		d.pre     = pre_tick ? '0 : q.pre + 2'h1;
		d.edge_s1 = edge_trigger_pin;
		d.edge_s2 = q.edge_s1;
		d.edge_p  = q.edge_s2;
		d.comp_s1 = comparator;
		d.comp_s2 = q.comp_s1;
		for (int i = 0; i < sas_pkg::NCONV; i++)
		begin
			arm  = 1'b0;
			halt = 1'b0;
			if (pre_tick && !power_down)
				d.cv[i].dcnt = (q.cv[i].dcnt == q.cv[i].div) ? '0 : q.cv[i].dcnt + 3'h1;
			// Register writes; flag clears come before the engine so that a new event wins.
			if (bus.wr && !bus.addr.bank && (bus.addr.conv == 1'(i)))
			begin
				case (bus.addr.idx)
					sas_pkg::REG_CTRL:
					begin
						ctl = sas_pkg::sas_ctrl_t'(bus.wdata);
						d.cv[i].ctrl = ctl;
						arm  = ctl.en;
						halt = !ctl.en;
					end
					sas_pkg::REG_CHAN:   d.cv[i].chan = sas_pkg::sas_chan_t'(bus.wdata);
					sas_pkg::REG_LIMHI:  d.cv[i].lim_hi = bus.wdata;
					sas_pkg::REG_LIMLO:  d.cv[i].lim_lo = bus.wdata;
					sas_pkg::REG_STAT:
					begin
						d.cv[i].done_f = q.cv[i].done_f && !bus.wdata[0];
						d.cv[i].lim_f  = q.cv[i].lim_f && !bus.wdata[1];
					end
					sas_pkg::REG_IEN:
					begin
						ien = sas_pkg::sas_ien_t'(bus.wdata);
						d.cv[i].done_ie = ien.done;
						d.cv[i].lim_ie  = ien.lim;
					end
					sas_pkg::REG_CLKDIV: d.cv[i].div = bus.wdata[2:0];
					sas_pkg::REG_CMD:
					begin
						cmd  = sas_pkg::sas_cmd_t'(bus.wdata);
						arm  = cmd.start && q.cv[i].ctrl.en;
						halt = cmd.stop;
					end
					default:
					begin
						if (bus.addr.idx == {sas_pkg::REG_RES_WIN, sas_pkg::RES_DAC})
							d.cv[i].res[sas_pkg::RES_DAC] = bus.wdata;
					end
				endcase
			end
			if (arm && !halt)
			begin
				nx = sas_pkg::sas_scan_next(d.cv[i].chan.mask, 3'h0);
				d.cv[i].ch  = sas_pkg::sas_is_scan(d.cv[i].ctrl.mode) ? nx[1:0] : d.cv[i].chan.first;
				d.cv[i].pos = '0;
				d.cv[i].go  = (d.cv[i].ctrl.start == sas_pkg::ST_IMMEDIATE)
					|| (d.cv[i].ctrl.start == sas_pkg::ST_DUAL);
				d.cv[i].ph  = (sas_pkg::sas_is_scan(d.cv[i].ctrl.mode) && !nx[2])
					? sas_pkg::PH_IDLE : sas_pkg::PH_ARMED;
				d.cv[i].ana.sample = 1'b0;
			end
			if (halt)
			begin
				d.cv[i].ph = sas_pkg::PH_IDLE;
				d.cv[i].go = 1'b0;
				d.cv[i].ana.sample = 1'b0;
			end
			// Conversion engine.
			if (!ctl_wr[i])
			begin
				unique case (q.cv[i].ph)
					sas_pkg::PH_IDLE:
					begin
						d.cv[i].go = 1'b0;
					end
					sas_pkg::PH_ARMED:
					begin
						if (strt[i])
						begin
							d.cv[i].ph = sas_pkg::PH_SAMPLE;
							d.cv[i].go = 1'b0;
							d.cv[i].tcnt = '0;
							d.cv[i].ana.sample = 1'b1;
						end
					end
					sas_pkg::PH_SAMPLE:
					begin
						if (tick[i] && (q.cv[i].tcnt == sas_pkg::SAMPLE_LAST))
						begin
							d.cv[i].ph = sas_pkg::PH_CONV;
							d.cv[i].ana.sample = 1'b0;
							d.cv[i].sar = sas_pkg::SAR_INIT;
							d.cv[i].bitn = sas_pkg::MSB_BIT;
							d.cv[i].full_chk = 1'b1;
						end
						else if (tick[i])
							d.cv[i].tcnt = q.cv[i].tcnt + 4'h1;
					end
					sas_pkg::PH_CONV:
					begin
						if (tick[i])
						begin
							// Keep the trial bit only when the input lies at or above the DAC level.
							nv = q.comp_s2[i] ? q.cv[i].sar
								: q.cv[i].sar & ~(sas_pkg::BIT_ONE << q.cv[i].bitn);
							if ((q.cv[i].bitn == sas_pkg::LIM_BIT)
								&& ((nv[7:4] > q.cv[i].lim_hi[7:4]) || (nv[7:4] < q.cv[i].lim_lo[7:4])))
							begin
								d.cv[i].full_chk = 1'b0;
								if (q.cv[i].lim_ie)
									d.cv[i].lim_f = 1'b1;
							end
							if (q.cv[i].bitn != sas_pkg::LSB_BIT)
							begin
								d.cv[i].sar = nv | (sas_pkg::BIT_ONE << (q.cv[i].bitn - 3'h1));
								d.cv[i].bitn = q.cv[i].bitn - 3'h1;
							end
							else
							begin
								d.cv[i].sar = nv;
								if (q.cv[i].full_chk && q.cv[i].lim_ie
									&& ((nv > q.cv[i].lim_hi) || (nv < q.cv[i].lim_lo)))
									d.cv[i].lim_f = 1'b1;
								idx = ((q.cv[i].ctrl.mode == sas_pkg::MD_FIX_CONT)
									|| (q.cv[i].ctrl.mode == sas_pkg::MD_DUAL_CONT)) ? q.cv[i].pos : q.cv[i].ch;
								d.cv[i].res[idx] = nv;
								nx = sas_pkg::sas_scan_next(q.cv[i].chan.mask, {1'b0, q.cv[i].ch} + 3'h1);
								d.cv[i].ph = sas_pkg::PH_SAMPLE;
								unique case (q.cv[i].ctrl.mode)
									sas_pkg::MD_FIX_SINGLE:
									begin
										d.cv[i].done_f = 1'b1;
										d.cv[i].ph = sas_pkg::PH_IDLE;
									end
									sas_pkg::MD_FIX_CONT:
									begin
										d.cv[i].pos = q.cv[i].pos + 2'h1;
										if (q.cv[i].pos == sas_pkg::POS_LAST)
											d.cv[i].done_f = 1'b1;
									end
									sas_pkg::MD_SCAN_SINGLE:
									begin
										if (nx[2])
											d.cv[i].ch = nx[1:0];
										else
										begin
											d.cv[i].done_f = 1'b1;
											d.cv[i].ph = sas_pkg::PH_IDLE;
										end
									end
									sas_pkg::MD_SCAN_CONT:
									begin
										if (!nx[2])
										begin
											d.cv[i].done_f = 1'b1;
											nx = sas_pkg::sas_scan_next(q.cv[i].chan.mask, 3'h0);
										end
										d.cv[i].ch = nx[1:0];
									end
									sas_pkg::MD_DUAL_CONT:
									begin
										d.cv[i].pos = q.cv[i].pos + 2'h1;
										d.cv[i].ch = q.cv[i].pos[0] ? q.cv[i].chan.first : q.cv[i].chan.second;
										if (q.cv[i].pos == sas_pkg::POS_LAST)
											d.cv[i].done_f = 1'b1;
									end
									sas_pkg::MD_SINGLE_STEP:
									begin
										d.cv[i].done_f = 1'b1;
										d.cv[i].ph = sas_pkg::PH_ARMED;
										if (!nx[2])
											nx = sas_pkg::sas_scan_next(q.cv[i].chan.mask, 3'h0);
										d.cv[i].ch = nx[1:0];
									end
									default:
									begin
										d.cv[i].ph = sas_pkg::PH_IDLE;
									end
								endcase
								if (d.cv[i].ph == sas_pkg::PH_SAMPLE)
								begin
									d.cv[i].tcnt = '0;
									d.cv[i].ana.sample = 1'b1;
								end
							end
						end
					end
				endcase
			end
			d.cv[i].ana.ch_sel = d.cv[i].ch;
			d.cv[i].ana.dac_code = d.cv[i].ctrl.dac ? d.cv[i].res[sas_pkg::RES_DAC] : d.cv[i].sar;
			d.cv[i].ana.dac_pin_en = d.cv[i].ctrl.dac && d.cv[i].ctrl.en;
			// Request stays active in processor idle, which is what wakes it.
			irq_v = irq_v || (d.cv[i].done_f && d.cv[i].done_ie)
				|| (d.cv[i].lim_f && d.cv[i].lim_ie);
			if (bus.rd && !bus.addr.bank && (bus.addr.conv == 1'(i)))
			begin
				case (bus.addr.idx)
					sas_pkg::REG_CTRL:   rd_v = q.cv[i].ctrl;
					sas_pkg::REG_CHAN:   rd_v = q.cv[i].chan;
					sas_pkg::REG_LIMHI:  rd_v = q.cv[i].lim_hi;
					sas_pkg::REG_LIMLO:  rd_v = q.cv[i].lim_lo;
					sas_pkg::REG_STAT:   rd_v = sas_pkg::sas_stat_t'({5'h0,
						(q.cv[i].ph == sas_pkg::PH_SAMPLE) || (q.cv[i].ph == sas_pkg::PH_CONV),
						q.cv[i].lim_f, q.cv[i].done_f});
					sas_pkg::REG_IEN:    rd_v = {6'h0, q.cv[i].lim_ie, q.cv[i].done_ie};
					sas_pkg::REG_CLKDIV: rd_v = {5'h0, q.cv[i].div};
					default:
					begin
						if (bus.addr.idx[3:2] == sas_pkg::REG_RES_WIN)
							rd_v = q.cv[i].res[bus.addr.idx[1:0]];
					end
				endcase
			end
		end
		d.irq   = irq_v;
		d.rdata = rd_v;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			q <= STATE_RST;
		else
			q <= d;
	end

	assign rd_data = q.rdata;
	assign irq     = q.irq;
	assign ana_out = {q.cv[1].ana, q.cv[0].ana};

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	a_single_done: assert property (q.cv[0].ph == sas_pkg::PH_CONV && tick[0]
		&& q.cv[0].bitn == sas_pkg::LSB_BIT && q.cv[0].ctrl.mode == sas_pkg::MD_FIX_SINGLE
		&& !ctl_wr[0] |=> q.cv[0].ph == sas_pkg::PH_IDLE && q.cv[0].done_f)
		else $error("Fixed single conversion did not finish idle with flag set.");
	a_fix_cont_wrap: assert property (q.cv[0].ph == sas_pkg::PH_CONV && tick[0]
		&& q.cv[0].bitn == sas_pkg::LSB_BIT && q.cv[0].ctrl.mode == sas_pkg::MD_FIX_CONT
		&& q.cv[0].pos == sas_pkg::POS_LAST && !ctl_wr[0]
		|=> q.cv[0].pos == '0 && q.cv[0].done_f && q.cv[0].ph == sas_pkg::PH_SAMPLE)
		else $error("Continuous fill did not wrap and flag after fourth result.");
	a_trig_ignored: assert property (q.cv[0].ph == sas_pkg::PH_CONV
		&& q.cv[0].bitn != sas_pkg::LSB_BIT |=> q.cv[0].ph != sas_pkg::PH_SAMPLE)
		else $error("A conversion was restarted before it completed.");
	a_dual_sync: assert property (strt[0] && dual_any
		&& q.cv[1].ph == sas_pkg::PH_ARMED && !ctl_wr[1] |=> q.cv[1].ph == sas_pkg::PH_SAMPLE)
		else $error("Dual start did not launch the second converter.");
	a_limit_upper: assert property (q.cv[0].ph == sas_pkg::PH_CONV && tick[0]
		&& q.cv[0].bitn == sas_pkg::LIM_BIT && q.cv[0].lim_ie
		&& {q.cv[0].sar[7:5], 1'b0} > q.cv[0].lim_hi[7:4] |=> q.cv[0].lim_f)
		else $error("Upper nibble above limit did not raise the limit flag.");
	a_limit_mask: assert property (!q.cv[0].lim_ie && !q.cv[0].lim_f |=> !q.cv[0].lim_f)
		else $error("Limit flag set while its enable was clear.");
	a_dac_follow: assert property (q.cv[0].ctrl.dac |->
		q.cv[0].ana.dac_code == q.cv[0].res[sas_pkg::RES_DAC]
		&& q.cv[0].ana.dac_pin_en == q.cv[0].ctrl.en)
		else $error("DAC output does not follow result register 3.");
	a_tick_spacing: assert property (tick[0] |=> !tick[0] [*3])
		else $error("Converter clock enables closer than the prescaler allows.");
	a_conv_bits: assert property ($rose(q.cv[0].ph == sas_pkg::PH_CONV)
		|-> (q.cv[0].bitn != sas_pkg::LSB_BIT) [*8])
		else $error("Conversion reached its last bit too early.");
	a_done_irq: assert property ($rose(q.cv[0].done_f) && q.cv[0].done_ie |-> irq)
		else $error("Enabled completion flag did not raise the request.");
	a_pd_hold: assert property (power_down && q.cv[0].ph == sas_pkg::PH_CONV && !ctl_wr[0]
		|=> q.cv[0].ph == sas_pkg::PH_CONV && $stable(q.cv[0].sar))
		else $error("Conversion advanced during power-down.");
	a_sar_msb: assert property (q.cv[0].ph == sas_pkg::PH_SAMPLE ##1
		q.cv[0].ph == sas_pkg::PH_CONV |-> q.cv[0].sar == sas_pkg::SAR_INIT
		&& q.cv[0].bitn == sas_pkg::MSB_BIT)
		else $error("Approximation did not begin with the top trial bit.");

endmodule : sas_sequencer

//--- test/sas_front_model.sv
// Behavioural sample-and-hold and comparator of both converters.
`timescale 1ns/1ps
module sas_front_model
(
	// Clock.
	input  wire logic                                   clock,
	// Controls from the sequencer.
	input  wire sas_pkg::sas_ana_t [sas_pkg::NCONV-1:0] ana_out,
	// Levels on the four inputs of each converter.
	input  wire logic [sas_pkg::NCONV-1:0][3:0][7:0]    vin,
	// Comparator outputs.
	output      logic [sas_pkg::NCONV-1:0]              comparator
);
	logic [sas_pkg::NCONV-1:0][7:0] held;

	initial held = '0;

	// The hold tracks the selected input only while sampling.
	always @(posedge clock)
	begin
		for (int g = 0; g < sas_pkg::NCONV; g++)
			if (ana_out[g].sample)
				held[g] <= vin[g][ana_out[g].ch_sel];
	end

	always_comb
	begin
		for (int g = 0; g < sas_pkg::NCONV; g++)
			comparator[g] = (held[g] >= ana_out[g].dac_code);
	end
endmodule : sas_front_model

//--- test/sas_sequencer_tb_top.sv
// Self-checking testbench of the converter sequencer.
`timescale 1ns/1ps
module sas_sequencer_tb_top;
	logic                                   clock;
	logic                                   rst;
	sas_pkg::sas_bus_t                      bus;
	logic [7:0]                             rd_data;
	logic                                   timer_ovf;
	logic                                   edge_trigger_pin;
	logic                                   power_down;
	logic [sas_pkg::NCONV-1:0]              comparator;
	sas_pkg::sas_ana_t [sas_pkg::NCONV-1:0] ana_out;
	logic                                   irq;
	logic [sas_pkg::NCONV-1:0][3:0][7:0]    vin;
	logic [7:0]                             exq[$];
	logic                                   rd_seen;
	logic [7:0]                             dv;
	int                                     err_count;
	int                                     checks;
	int                                     cyc;
	int                                     n;
	localparam logic [7:0] LV [5] = '{8'h95, 8'h85, 8'h70, 8'h3C, 8'h95};
	localparam logic [4:0] LE     = 5'b01111;
	localparam logic [4:0] LX     = 5'b01011;
	localparam int         TK     = sas_pkg::CONV_TICKS;

	sas_sequencer uut (.clock(clock), .rst(rst), .bus(bus), .rd_data(rd_data),
		.timer_ovf(timer_ovf), .edge_trigger_pin(edge_trigger_pin), .power_down(power_down),
		.comparator(comparator), .ana_out(ana_out), .irq(irq));

	sas_front_model front (.clock(clock), .ana_out(ana_out), .vin(vin),
		.comparator(comparator));

	initial clock = 1'b0;
	always #10 clock = ~clock;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		bus <= '0;
		@(posedge clock);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exq.push_back(e);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		bus <= '0;
		@(posedge clock);
	endtask : rd

	task automatic res(input logic c, input logic [1:0] ch, input logic [7:0] e);
		rd({1'b0, c, sas_pkg::REG_RES_WIN, ch}, e);
	endtask : res

	task automatic clr(input logic c);
		wr({1'b0, c, sas_pkg::REG_STAT}, 8'h03);
		repeat (2) @(posedge clock);
	endtask : clr

	task automatic pulse;
		timer_ovf <= 1'b1;
		@(posedge clock);
		timer_ovf <= 1'b0;
		@(posedge clock);
	endtask : pulse

	task automatic wait_irq;
		n = 0;
		while (irq !== 1'b1 && n < 3000)
		begin
			@(posedge clock);
			n++;
		end
		if (n >= 3000)
		begin
			err_count++;
			$display("mismatch at %0t: no completion", $time);
		end
	endtask : wait_irq

	// Read results come back one cycle after the strobe.
	always @(posedge clock)
	begin
		if (rd_seen)
		begin
			if (exq.size() == 0)
				check(rd_data, 16'hFFFF);
			else
				check(rd_data, exq.pop_front());
		end
		rd_seen <= bus.rd;
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			$display("mismatch at %0t: run too long", $time);
			results();
		end
	end

	initial
	begin
		bus = '0;
		rst = 1'b1;
		timer_ovf = 1'b0;
		edge_trigger_pin = 1'b1;
		power_down = 1'b0;
		vin = '0;
		rd_seen = 1'b0;
		err_count = 0;
		checks = 0;
		cyc = 0;
		void'($urandom(53));
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check(irq, 1'b0);
		rd(6'h00, 8'h00);
		rd(6'h20, 8'h00);
		rd(6'h0C, 8'h00);
		wr(6'h05, 8'h01);
		wr(6'h15, 8'h01);
		for (int d = 0; d < 8; d += 7)
		begin
			vin <= {$urandom, $urandom};
			wr(6'h06, 8'(d));
			wr(6'h01, 8'h20);
			wr(6'h00, 8'h28);
			wait_irq();
			check(n >= (TK-1)*4*(d+1) && n <= (TK+1)*4*(d+1)+4, 1'b1);
			res(1'b0, 2'h2, vin[0][2]);
			wr(6'h05, 8'h00);
			repeat (2) @(posedge clock);
			check(irq, 1'b0);
			wr(6'h05, 8'h01);
			repeat (2) @(posedge clock);
			check(irq, 1'b1);
			clr(1'b0);
			check(irq, 1'b0);
		end
		wr(6'h06, 8'h00);
		wr(6'h01, 8'h10);
		wr(6'h00, 8'h29);
		wait_irq();
		check(n >= 4*(TK-1)*4, 1'b1);
		vin <= {$urandom, $urandom};
		clr(1'b0);
		wait_irq();
		wr(6'h07, 8'h02);
		for (int k = 0; k < 4; k++)
			res(1'b0, 2'(k), vin[0][1]);
		clr(1'b0);
		repeat (300) @(posedge clock);
		check(irq, 1'b0);
		vin <= {$urandom, $urandom};
		wr(6'h11, 8'h0B);
		wr(6'h10, 8'h2A);
		wait_irq();
		check(n >= 3*(TK-1)*4, 1'b1);
		for (int k = 0; k < 4; k++)
			res(1'b1, 2'(k), (k == 2) ? 8'h00 : vin[1][k]);
		clr(1'b1);
		wr(6'h10, 8'h2B);
		wait_irq();
		clr(1'b1);
		vin <= {$urandom, $urandom};
		wait_irq();
		wr(6'h17, 8'h02);
		res(1'b1, 2'h0, vin[1][0]);
		res(1'b1, 2'h3, vin[1][3]);
		clr(1'b1);
		wr(6'h11, 8'hC0);
		wr(6'h10, 8'h2C);
		wait_irq();
		wr(6'h17, 8'h02);
		for (int k = 0; k < 4; k++)
			res(1'b1, 2'(k), vin[1][(k % 2) * 3]);
		clr(1'b1);
		vin <= {$urandom, $urandom};
		wr(6'h01, 8'h06);
		wr(6'h00, 8'h25);
		pulse();
		repeat (8) @(posedge clock);
		pulse();
		wait_irq();
		res(1'b0, 2'h1, vin[0][1]);
		clr(1'b0);
		repeat (150) @(posedge clock);
		check(irq, 1'b0);
		pulse();
		wait_irq();
		res(1'b0, 2'h2, vin[0][2]);
		clr(1'b0);
		wr(6'h01, 8'h30);
		wr(6'h00, 8'h30);
		edge_trigger_pin <= 1'b0;
		repeat (8) @(posedge clock);
		edge_trigger_pin <= 1'b1;
		wait_irq();
		res(1'b0, 2'h3, vin[0][3]);
		clr(1'b0);
		repeat (150) @(posedge clock);
		check(irq, 1'b0);
		vin <= {$urandom, $urandom};
		wr(6'h11, 8'h10);
		wr(6'h10, 8'h20);
		wr(6'h01, 8'h20);
		wr(6'h00, 8'h38);
		repeat (2) @(posedge clock);
		check(ana_out[0].sample & ana_out[1].sample, 1'b1);
		wait_irq();
		res(1'b0, 2'h2, vin[0][2]);
		res(1'b1, 2'h1, vin[1][1]);
		clr(1'b0);
		clr(1'b1);
		wr(6'h02, 8'h80);
		wr(6'h03, 8'h40);
		wr(6'h01, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			vin[0][0] <= LV[i];
			wr(6'h05, {6'h00, LE[i], 1'b0});
			wr(6'h00, 8'h28);
			repeat ((TK+3)*4) @(posedge clock);
			check(irq, LX[i]);
			rd(6'h04, {6'h00, LX[i], 1'b1});
			clr(1'b0);
		end
		wr(6'h05, 8'h01);
		vin <= {$urandom, $urandom};
		wr(6'h00, 8'h28);
		power_down <= 1'b1;
		repeat (400) @(posedge clock);
		check(irq, 1'b0);
		power_down <= 1'b0;
		wait_irq();
		res(1'b0, 2'h0, vin[0][0]);
		clr(1'b0);
		vin <= {$urandom, $urandom};
		wr(6'h07, 8'h01);
		wait_irq();
		res(1'b0, 2'h0, vin[0][0]);
		clr(1'b0);
		dv = 8'($urandom);
		wr(6'h00, 8'h66);
		wr(6'h0B, dv);
		repeat (2) @(posedge clock);
		check(ana_out[0].dac_code, dv);
		check(ana_out[0].dac_pin_en, 1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check(ana_out[0].dac_pin_en, 1'b0);
		rd(6'h0B, 8'h00);
		results();
	end
endmodule : sas_sequencer_tb_top
